// File: rtl/charger_cfg_pkg.sv
// shared constants and types for the charger configuration register bank
package charger_cfg_pkg;

    // ==================================================
    // register addresses (I2C register index)
    localparam logic [7:0] ADDR_POWER_ON_CONFIGURATION = 8'h01;
    localparam logic [7:0] ADDR_FAST_CHARGE_CURRENT_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_PRECHARGE_TERMINATION_CURRENT = 8'h03;

    // ==================================================
    // reset values
    localparam logic [7:0] RST_POWER_ON_CONFIGURATION = 8'h1B;
    localparam logic [7:0] RST_FAST_CHARGE_CURRENT_CONTROL = 8'h60;
    localparam logic [7:0] RST_PRECHARGE_TERMINATION_CURRENT = 8'h11;

    // ==================================================
    // field positions
    localparam int BIT_REGISTER_RESET = 7;
    localparam int BIT_WATCHDOG_KICK = 6;
    localparam int BIT_MODE_HI = 5;
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_SYSMIN_HI = 3;
    localparam int BIT_SYSMIN_LO = 1;
    localparam int BIT_BOOST_LIMIT = 0;
    localparam int BIT_FASTCHG_HI = 7;
    localparam int BIT_FASTCHG_LO = 2;
    localparam int BIT_CHG_RESERVED = 1;
    localparam int BIT_REDUCED = 0;
    localparam int BIT_PRECHG_HI = 7;
    localparam int BIT_PRECHG_LO = 4;
    localparam int BIT_TERM_HI = 3;
    localparam int BIT_TERM_LO = 0;

    // ==================================================
    // field encodings in the decoded settings (mA / mV units)
    localparam logic [11:0] SYSMIN_OFFSET_MV = 12'hBB8;
    localparam logic [11:0] SYSMIN_STEP_MV = 12'h064;
    localparam logic [11:0] FASTCHG_OFFSET_MA = 12'h200;
    localparam logic [11:0] FASTCHG_STEP_MA = 12'h040;
    localparam logic [11:0] PRECHG_STEP_MA = 12'h080;
    localparam logic [11:0] BOOST_LOW_MA = 12'h1F4;
    localparam logic [11:0] BOOST_HIGH_MA = 12'h514;

    typedef enum logic [1:0]
    {
        MODE_DISABLED,
        MODE_CHARGE,
        MODE_BOOST
    } charger_mode_t;

    // decoded settings handed to the charge loops
    typedef struct packed
    {
        charger_mode_t mode;
        logic [11:0] minimum_system_voltage_mv;
        logic [11:0] boost_current_limit_ma;
        logic [11:0] fast_charge_current_ma;
        logic [11:0] precharge_current_ma;
        logic [11:0] termination_current_ma;
        logic reduced_current_select;
    } charge_settings_t;

    // register access from the I2C protocol engine
    typedef struct packed
    {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_t;

endpackage

// File: rtl/charger_config_registers.sv
// configuration register bank of the battery charger
`timescale 1ns/1ps

// What this block does
// - writing one to the register reset bit returns all registers to defaults, bit self-clears.
// - writing one to the watchdog kick bit restarts the watchdog and the bit reads back zero.
// - the mode field selects disabled for 00, charging for 01 and boost for 10 or 11.
// - minimum system voltage is 3.0 V plus 0.1 V per code step, reset code 101.
// - the boost limit bit gives 500 mA when zero and 1.3 A when one, reset one.
// - fast charge current is 512 mA plus 64 mA per code step, wrapping past 4095 mA from code 56, reset code 011000.
// - reduced current select scales fast charge to 20% and pre-charge to 50%.
// - pre-charge and termination currents are 128 mA plus 128 mA per step, reset 0001.
module charger_config_registers
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register access from the protocol engine
    input charger_cfg_pkg::reg_access_t acc,
    output logic [7:0] rdata,
    output logic addr_valid,
    // outputs to the charge loops
    output logic watchdog_restart,
    output charger_cfg_pkg::charge_settings_t settings
);
    import charger_cfg_pkg::*;

    logic [7:0] pwr_cfg_reg;
    logic [7:0] chg_cur_reg;
    logic [7:0] pre_term_reg;
    logic wr_pwr;
    logic wr_chg;
    logic wr_pre;
    logic reg_reset;
    logic [7:0] rdata_next;
    logic addr_valid_next;
    charge_settings_t settings_next;
    logic [11:0] fast_ma;
    logic [11:0] pre_ma;
    logic [25:0] fast_scaled;

    assign wr_pwr = acc.wr && (acc.addr == ADDR_POWER_ON_CONFIGURATION);
    assign wr_chg = acc.wr && (acc.addr == ADDR_FAST_CHARGE_CURRENT_CONTROL);
    assign wr_pre = acc.wr && (acc.addr == ADDR_PRECHARGE_TERMINATION_CURRENT);
    // a write of the reset bit wins over the other bits of the same write, except the watchdog kick, which still pulses
    assign reg_reset = wr_pwr && acc.wdata[BIT_REGISTER_RESET];

    // ==================================================
    // register storage
    always_ff @(posedge clk)
    begin
        if (rst || reg_reset)
        begin
            pwr_cfg_reg <= RST_POWER_ON_CONFIGURATION;
            chg_cur_reg <= RST_FAST_CHARGE_CURRENT_CONTROL;
            pre_term_reg <= RST_PRECHARGE_TERMINATION_CURRENT;
        end
        else
        begin
            if (wr_pwr)
            begin
                // self-clearing bits are never stored
                pwr_cfg_reg <= {2'b00, acc.wdata[5:0]};
            end
            if (wr_chg)
            begin
                // reserved bit kept at zero even if the host breaks its contract
                chg_cur_reg <= {acc.wdata[7:2], 1'b0, acc.wdata[0]};
            end
            if (wr_pre)
            begin
                pre_term_reg <= acc.wdata;
            end
        end
    end

    // ==================================================
    // watchdog restart pulse
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            watchdog_restart <= 1'b0;
        end
        else
        begin
            watchdog_restart <= wr_pwr && acc.wdata[BIT_WATCHDOG_KICK];
        end
    end

    // ==================================================
    // read path
    always_comb
    begin
        rdata_next = 8'h00;
        addr_valid_next = 1'b1;
        case (acc.addr)
            ADDR_POWER_ON_CONFIGURATION: rdata_next = pwr_cfg_reg;
            ADDR_FAST_CHARGE_CURRENT_CONTROL: rdata_next = chg_cur_reg;
            ADDR_PRECHARGE_TERMINATION_CURRENT: rdata_next = pre_term_reg;
            default: addr_valid_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
            addr_valid <= 1'b0;
        end
        else
        begin
            rdata <= rdata_next;
            addr_valid <= addr_valid_next;
        end
    end

    // ==================================================
    // field decode
    always_comb
    begin
        settings_next = '0;
        case (pwr_cfg_reg[BIT_MODE_HI:BIT_MODE_LO])
            2'b00: settings_next.mode = MODE_DISABLED;
            2'b01: settings_next.mode = MODE_CHARGE;
            default: settings_next.mode = MODE_BOOST;
        endcase
        settings_next.minimum_system_voltage_mv = SYSMIN_OFFSET_MV
            + 12'(SYSMIN_STEP_MV * 12'(pwr_cfg_reg[BIT_SYSMIN_HI:BIT_SYSMIN_LO]));
        settings_next.boost_current_limit_ma = pwr_cfg_reg[BIT_BOOST_LIMIT]
            ? BOOST_HIGH_MA : BOOST_LOW_MA;
        fast_ma = FASTCHG_OFFSET_MA
            + 12'(FASTCHG_STEP_MA * 12'(chg_cur_reg[BIT_FASTCHG_HI:BIT_FASTCHG_LO]));
        pre_ma = PRECHG_STEP_MA
            + 12'(PRECHG_STEP_MA * 12'(pre_term_reg[BIT_PRECHG_HI:BIT_PRECHG_LO]));
        // 20% as x*13108/65536 avoids a divider; the result is truncated down
        // 26 bits hold the widest product, a narrower one wraps at the top codes
        fast_scaled = 26'(fast_ma) * 26'h0003334;
        settings_next.reduced_current_select = chg_cur_reg[BIT_REDUCED];
        settings_next.fast_charge_current_ma = fast_ma;
        if (chg_cur_reg[BIT_REDUCED])
        begin
            settings_next.fast_charge_current_ma = 12'(fast_scaled >> 16);
        end
        settings_next.precharge_current_ma = chg_cur_reg[BIT_REDUCED]
            ? {1'b0, pre_ma[11:1]} : pre_ma;
        settings_next.termination_current_ma = PRECHG_STEP_MA
            + 12'(PRECHG_STEP_MA * 12'(pre_term_reg[BIT_TERM_HI:BIT_TERM_LO]));
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            settings <= '0;
        end
        else
        begin
            settings <= settings_next;
        end
    end

    // ==================================================
    // checks
    sequence s_reset_write;
        wr_pwr && acc.wdata[BIT_REGISTER_RESET];
    endsequence

    a_regreset_defaults: assert property (@(posedge clk) disable iff (rst)
        s_reset_write |=> pwr_cfg_reg == RST_POWER_ON_CONFIGURATION
            && chg_cur_reg == RST_FAST_CHARGE_CURRENT_CONTROL
            && pre_term_reg == RST_PRECHARGE_TERMINATION_CURRENT)
        else $error("register reset did not restore defaults");

    sequence s_kick_write;
        wr_pwr && acc.wdata[BIT_WATCHDOG_KICK];
    endsequence

    a_kick_selfclear: assert property (@(posedge clk) disable iff (rst)
        s_kick_write |=> watchdog_restart && !pwr_cfg_reg[BIT_WATCHDOG_KICK])
        else $error("watchdog kick not pulsed or not cleared");

    a_kick_one_cycle: assert property (@(posedge clk) disable iff (rst)
        !(wr_pwr && acc.wdata[BIT_WATCHDOG_KICK]) |=> !watchdog_restart)
        else $error("watchdog restart pulse without a kick");

    a_mode_decode: assert property (@(posedge clk) disable iff (rst)
        ##1 (pwr_cfg_reg[5:4] == 2'b01 && $stable(pwr_cfg_reg)) |=> settings.mode == MODE_CHARGE)
        else $error("mode code 01 did not select charging");

    a_sysmin_value: assert property (@(posedge clk) disable iff (rst)
        ##1 $stable(pwr_cfg_reg) |=> settings.minimum_system_voltage_mv
            == 12'hBB8 + 12'(12'h064 * 12'($past(pwr_cfg_reg[3:1]))))
        else $error("minimum system voltage decode wrong");

    a_boost_value: assert property (@(posedge clk) disable iff (rst)
        ##1 $stable(pwr_cfg_reg) |=> settings.boost_current_limit_ma
            == ($past(pwr_cfg_reg[0]) ? 12'h514 : 12'h1F4))
        else $error("boost limit decode wrong");

    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        wr_chg |=> !chg_cur_reg[BIT_CHG_RESERVED])
        else $error("reserved bit stored as one");

    a_reduced_half: assert property (@(posedge clk) disable iff (rst)
        ##1 ($stable(chg_cur_reg) && $stable(pre_term_reg) && chg_cur_reg[0])
            |=> settings.precharge_current_ma
                == 12'h040 + 12'(12'h040 * 12'($past(pre_term_reg[7:4]))))
        else $error("reduced pre-charge is not half");

    a_hold_value: assert property (@(posedge clk) disable iff (rst)
        !acc.wr |=> $stable(pwr_cfg_reg) && $stable(chg_cur_reg) && $stable(pre_term_reg))
        else $error("register changed without a write");

    a_fast_value: assert property (@(posedge clk) disable iff (rst)
        ##1 ($stable(chg_cur_reg) && !chg_cur_reg[BIT_REDUCED]) |=> settings.fast_charge_current_ma
            == 12'h200 + 12'(12'h040 * 12'($past(chg_cur_reg[7:2]))))
        else $error("fast charge current decode wrong");

    a_term_value: assert property (@(posedge clk) disable iff (rst)
        ##1 $stable(pre_term_reg) |=> settings.termination_current_ma
            == 12'h080 + 12'(12'h080 * 12'($past(pre_term_reg[3:0]))))
        else $error("termination current decode wrong");

    a_read_stored: assert property (@(posedge clk) disable iff (rst)
        ##1 (acc.addr == ADDR_FAST_CHARGE_CURRENT_CONTROL) |=> rdata == $past(chg_cur_reg))
        else $error("read data differs from stored bits");

endmodule

// File: tb/host_access_model.sv
// host side model presenting byte accesses to the register bank
`timescale 1ns/1ps

module host_access_model
(
    // requests from the bench
    input wire logic req_wr,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_wdata,
    // access toward the bank
    output charger_cfg_pkg::reg_access_t acc
);
    import charger_cfg_pkg::*;

    // ==================================================
    // reserved charge current bit always written as zero
    always_comb
    begin
        acc.wr = req_wr;
        acc.addr = req_addr;
        acc.wdata = req_wdata;
        if (req_addr == ADDR_FAST_CHARGE_CURRENT_CONTROL)
        begin
            acc.wdata[BIT_CHG_RESERVED] = 1'b0;
        end
    end
endmodule

// File: tb/tb_charger_config_registers.sv
// self-checking bench for the charger configuration register bank
`timescale 1ns/1ps

module tb_charger_config_registers;
    import charger_cfg_pkg::*;

    // ==================================================
    // signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_wr = 1'b0;
    logic [7:0] req_addr = 8'h00;
    logic [7:0] req_wdata = 8'h00;
    reg_access_t acc;
    logic [7:0] rdata;
    logic addr_valid;
    logic watchdog_restart;
    charge_settings_t settings;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [7:0] rd;
    logic [7:0] d;
    logic [2:0] k;

    host_access_model host_access_model_inst (.req_wr(req_wr), .req_addr(req_addr),
        .req_wdata(req_wdata), .acc(acc));
    charger_config_registers charger_config_registers_inst (.clk(clk), .rst(rst),
        .acc(acc), .rdata(rdata), .addr_valid(addr_valid),
        .watchdog_restart(watchdog_restart), .settings(settings));

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // ==================================================
    // tasks
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // returns just after the edge taking the write, where the kick pulse shows
    task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        req_wr <= 1'b1;
        req_addr <= a;
        req_wdata <= v;
        @(posedge clk);
        req_wr <= 1'b0;
        #1;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        req_addr <= a;
        @(posedge clk);
        #1;
        v = rdata;
    endtask

    task automatic check_defaults;
        read_reg(ADDR_POWER_ON_CONFIGURATION, rd);
        check("power_on_configuration", 12'(rd), 12'(RST_POWER_ON_CONFIGURATION));
        check("addr_valid", 12'(addr_valid), 12'h001);
        read_reg(ADDR_FAST_CHARGE_CURRENT_CONTROL, rd);
        check("fast_charge_current_control", 12'(rd), 12'h060);
        read_reg(ADDR_PRECHARGE_TERMINATION_CURRENT, rd);
        check("precharge_termination_current", 12'(rd), 12'h011);
        check("mode", 12'(settings.mode), 12'(MODE_CHARGE));
        check("sysmin", settings.minimum_system_voltage_mv, 12'hDAC);
        check("boost", settings.boost_current_limit_ma, 12'h514);
        check("fast", settings.fast_charge_current_ma, 12'h800);
        check("prechg", settings.precharge_current_ma, 12'h100);
        check("term", settings.termination_current_ma, 12'h100);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        n_mismatch++;
        $display("ERROR timeout expected end seen hang");
        finish_test();
    end

    // ==================================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check_defaults();
        read_reg(8'h04, rd);
        check("unmapped", 12'(rd), 12'h000);
        check("addr_valid", 12'(addr_valid), 12'h000);
        $display("test reset_values done");
        // every mode code, voltage code and both boost limits
        for (int i = 0; i < 8; i++)
        begin
            k = 3'(i);
            d = {2'b00, k[1:0], k, k[2]};
            write_reg(ADDR_POWER_ON_CONFIGURATION, d);
            read_reg(ADDR_POWER_ON_CONFIGURATION, rd);
            check("power_on_configuration", 12'(rd), 12'(d));
            check("mode", 12'(settings.mode),
                12'(k[1:0] == 2'b00 ? MODE_DISABLED : k[1] ? MODE_BOOST : MODE_CHARGE));
            check("sysmin", settings.minimum_system_voltage_mv,
                SYSMIN_OFFSET_MV + 12'(k) * SYSMIN_STEP_MV);
            check("boost", settings.boost_current_limit_ma,
                k[2] ? BOOST_HIGH_MA : BOOST_LOW_MA);
        end
        $display("test configuration_fields done");
        // fast code 31 and top pre-charge code, plain and reduced; 20% is truncated
        for (int r = 0; r < 2; r++)
        begin
            write_reg(ADDR_FAST_CHARGE_CURRENT_CONTROL, {6'd31, 1'b1, 1'(r)});
            write_reg(ADDR_PRECHARGE_TERMINATION_CURRENT, 8'hF0);
            read_reg(ADDR_FAST_CHARGE_CURRENT_CONTROL, rd);
            check("fast_charge_current_control", 12'(rd), 12'({6'd31, 1'b0, 1'(r)}));
            check("fast", settings.fast_charge_current_ma, r ? 12'h1F3 : 12'h9C0);
            check("prechg", settings.precharge_current_ma, r ? 12'h400 : 12'h800);
            check("term", settings.termination_current_ma, 12'h080);
            check("reduced", 12'(settings.reduced_current_select), 12'(r));
        end
        write_reg(8'h04, 8'hFF);
        read_reg(ADDR_PRECHARGE_TERMINATION_CURRENT, rd);
        check("precharge_termination_current", 12'(rd), 12'h0F0);
        $display("test charge_currents done");
        // host keeps control by kicking twice
        repeat (2)
        begin
            write_reg(ADDR_POWER_ON_CONFIGURATION, 8'h40);
            check("watchdog_restart", 12'(watchdog_restart), 12'h001);
        end
        read_reg(ADDR_POWER_ON_CONFIGURATION, rd);
        check("power_on_configuration", 12'(rd), 12'h000);
        check("watchdog_restart", 12'(watchdog_restart), 12'h000);
        $display("test watchdog_kick done");
        write_reg(ADDR_POWER_ON_CONFIGURATION, 8'h80);
        check_defaults();
        $display("test register_reset done");
        finish_test();
    end
endmodule
